// ---- dv/core_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// Core model: a stopped core fetches nothing, so requests are dropped
module core_model (
  // Clock and core state
  input wire logic clk_i,
  input wire logic exec_en_i,
  // Bench requests
  input wire logic do_sleep_i,
  input wire logic do_clear_i,
  // Instruction pulses
  output logic sleep_o,
  output logic clear_o
);
  always_ff @(posedge clk_i) begin
    sleep_o <= do_sleep_i & exec_en_i;
    clear_o <= do_clear_i & exec_en_i;
  end
endmodule : core_model

// ---- dv/mode_reset_sva.sv ----
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the mode and reset sequencer
module mode_reset_sva
  import mode_reset_pkg::*;
(
  // Clock, reset, events and wake sources
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic power_on_reset_i,
  input wire logic low_voltage_reset_i,
  input wire logic external_reset_pin_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic timer0_overflow_i,
  input wire logic portb_change_i,
  input wire logic ext_int_i,
  input wire logic sleep_instruction_i,
  // Gating outputs
  input wire logic low_frequency_clock_en_o,
  input wire logic exec_en_o,
  input wire logic timer0_run_o,
  input wire logic timer1_run_o,
  input wire logic periph_en_o,
  input wire logic watchdog_clear_o,
  input wire logic sys_reset_o,
  input wire logic [1:0] mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wire logic evt = power_on_reset_i | low_voltage_reset_i | !external_reset_pin_n_i
    | watchdog_timeout_i;
  wire logic halted = mode_o == MODE_HALT && !low_frequency_clock_en_o;
  wire logic halt_src = ext_int_i | portb_change_i;
  wire logic stby_src = timer0_overflow_i | portb_change_i | ext_int_i;

  sequence s_halt_entry;
    sleep_instruction_i && exec_en_o && !evt;
  endsequence
  // Halt wake: 16 idle cycles of count, then run on the next one
  sequence s_wake_count;
    !exec_en_o [*8] ##1 !exec_en_o [*8] ##1 exec_en_o;
  endsequence

  property p_halt_gate;
    mode_o == MODE_HALT |-> !exec_en_o && !timer0_run_o && !timer1_run_o && !periph_en_o;
  endproperty
  property p_losc_off;
    !low_frequency_clock_en_o |-> mode_o == MODE_HALT;
  endproperty
  property p_exec_reset;
    sys_reset_o |-> !exec_en_o;
  endproperty
  property p_sleep;
    s_halt_entry |=> (halted && watchdog_clear_o) ##1 !watchdog_clear_o;
  endproperty
  property p_reset;
    evt |=> sys_reset_o;
  endproperty
  property p_release;
    $fell(evt) |-> sys_reset_o [*8];
  endproperty
  property p_halt_wake;
    halted && halt_src && !evt |=> s_wake_count;
  endproperty
  property p_halt_hold;
    halted && !halt_src && !evt |=> mode_o == MODE_HALT;
  endproperty
  property p_stby_wake;
    mode_o == MODE_STANDBY && stby_src && !evt |=> exec_en_o;
  endproperty

  a_halt_gate: assert property (p_halt_gate) else $error("resource on in halt");
  a_losc_off: assert property (p_losc_off) else $error("low clock off outside halt");
  a_exec_reset: assert property (p_exec_reset) else $error("executing in reset");
  a_sleep: assert property (p_sleep) else $error("sleep did not halt");
  a_reset: assert property (p_reset) else $error("event without reset");
  a_release: assert property (p_release) else $error("reset left too early");
  a_halt_wake: assert property (p_halt_wake) else $error("halt wake count wrong");
  a_halt_hold: assert property (p_halt_hold) else $error("halt left without source");
  a_stby_wake: assert property (p_stby_wake) else $error("standby wake late");
endmodule : mode_reset_sva

bind mode_and_reset_sequencer mode_reset_sva u_sva (.*);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import mode_reset_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] evt = 4'h0;
  logic [4:0] src = 5'h0;
  wire logic power_on_reset_i = evt[0], low_voltage_reset_i = evt[1];
  wire logic external_reset_pin_n_i = !evt[2], watchdog_timeout_i = evt[3];
  wire logic timer0_overflow_i = src[0], timer1_underflow_i = src[1], portb_change_i = src[2];
  wire logic ext_int_i = src[3], low_voltage_detect_i = src[4];
  logic do_sleep = 1'b0, do_clear = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
  logic sleep_instruction_i, watchdog_clear_instruction_i, sys_reset_o, irq_o;
  logic high_frequency_clock_en_o, low_frequency_clock_en_o, exec_en_o, timer0_run_o;
  logic timer1_run_o, watchdog_run_o, periph_en_o, watchdog_clear_o;
  logic [1:0] mode_o;
  int n_mismatch = 0, num_checks = 0, n;
  int dly[8] = '{10, 20, 30, 40, 50, 50, 50, 50};

  mode_and_reset_sequencer #(.DLY0_CYCLES(10), .DLY1_CYCLES(20), .DLY2_CYCLES(30),
    .DLY3_CYCLES(40), .DLY4_CYCLES(50)) dut (.*);
  core_model u_core (.clk_i(clk_i), .exec_en_i(exec_en_o), .do_sleep_i(do_sleep),
    .do_clear_i(do_clear), .sleep_o(sleep_instruction_i), .clear_o(watchdog_clear_instruction_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ==========================================================
  // Bus, event and compare tasks
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  function automatic logic [7:0] in_rng(input int v, input int lo);
    return {7'h0, v >= lo && v <= lo + 8};
  endfunction : in_rng

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp, what);
  endtask : rd

  // Bounded: a sequencer stuck in reset ends the run
  task automatic wait_run();
    n = 0;
    #1;
    while (exec_en_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 400) begin
        n_mismatch++;
        complete_run();
      end
    end
  endtask : wait_run

  task automatic rst_evt(input int k);
    @(posedge clk_i);
    evt[k] <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1 chk({7'h0, sys_reset_o}, 8'h01, "in reset");
    @(posedge clk_i);
    evt <= 4'h0;
    wait_run();
  endtask : rst_evt

  task automatic pulse(input int k);
    @(posedge clk_i);
    src[k] <= 1'b1;
    @(posedge clk_i);
    src[k] <= 1'b0;
    #1;
  endtask : pulse

  task automatic instr(input logic s);
    @(posedge clk_i);
    do_sleep <= s;
    do_clear <= !s;
    @(posedge clk_i);
    do_sleep <= 1'b0;
    do_clear <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : instr

  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_run();
    chk(in_rng(n, dly[0] + 14), 8'h01, "first power-up");
    rd(ADDR_CTRL, CTRL_INIT, "ctrl init");
    chk({7'h0, watchdog_run_o}, 8'h01, "watchdog run");
    rd(8'h3c, 8'h00, "unmapped read");
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CONFIG, 8'(c));
      wr(ADDR_CTRL, 8'h30);
      chk({7'h0, watchdog_run_o}, 8'h00, "watchdog off");
      rst_evt(c % 2);
      chk(in_rng(n, dly[c] + 14), 8'h01, "power-up delay");
      rd(ADDR_STATUS, 8'h03, "flags power");
      rd(ADDR_CTRL, CTRL_INIT, "ctrl reload");
      rd(ADDR_CONFIG, 8'(c), "config kept");
    end
    rst_evt(3);
    rd(ADDR_STATUS, 8'h02, "watchdog in run");
    rst_evt(2);
    rd(ADDR_STATUS, 8'h02, "pin in run");
    instr(1'b0);
    rd(ADDR_STATUS, 8'h03, "clear instruction");
    instr(1'b1);
    rd(ADDR_STATUS, 8'h0d, "sleep");
    rst_evt(2);
    rd(ADDR_STATUS, 8'h03, "pin in halt");
    instr(1'b1);
    rst_evt(3);
    rd(ADDR_STATUS, 8'h00, "watchdog in halt");
    // Overlapping events: reset must last until the last one goes
    @(posedge clk_i);
    evt <= 4'h5;
    @(posedge clk_i);
    evt <= 4'h4;
    repeat (20) @(posedge clk_i);
    #1 chk({7'h0, sys_reset_o}, 8'h01, "pin still held");
    @(posedge clk_i);
    evt <= 4'h0;
    wait_run();
    chk(in_rng(n, dly[7] + 14), 8'h01, "delay after last");
    rd(ADDR_STATUS, 8'h03, "flags after power-on");
    wr(ADDR_INT_STATUS, 8'h0f);
    wr(ADDR_INT_MASK, 8'h02);
    for (int k = 0; k < 5; k++) begin
      wr(ADDR_CTRL, 8'hda);
      chk({exec_en_o, timer0_run_o, timer1_run_o, periph_en_o, low_frequency_clock_en_o,
        high_frequency_clock_en_o, mode_o}, {6'b010110, MODE_STANDBY}, "standby gate");
      pulse(k);
      chk({6'h0, mode_o}, {6'h0, MODE_SLOW}, "standby wake");
    end
    chk({7'h0, irq_o}, 8'h01, "irq raised");
    rd(ADDR_INT_STATUS, 8'h02, "wake status");
    wr(ADDR_INT_MASK, 8'h00);
    chk({7'h0, irq_o}, 8'h00, "irq masked");
    wr(ADDR_INT_STATUS, 8'h02);
    wr(ADDR_INT_MASK, 8'h02);
    chk({7'h0, irq_o}, 8'h00, "irq cleared");
    wr(ADDR_CTRL, 8'hc9);
    chk({7'h0, high_frequency_clock_en_o}, 8'h01, "standby keeps osc");
    pulse(0);
    chk({6'h0, mode_o}, {6'h0, MODE_NORMAL}, "wake normal");
    wr(ADDR_CTRL, 8'hc5);
    chk({4'h0, high_frequency_clock_en_o, low_frequency_clock_en_o, mode_o},
      {6'h0, MODE_HALT}, "halt gate");
    for (int k = 0; k < 5; k++) begin
      if (k != 2 && k != 3) begin
        pulse(k);
        chk({6'h0, mode_o}, {6'h0, MODE_HALT}, "halt ignores");
      end
    end
    pulse(3);
    wait_run();
    chk(in_rng(n, 13), 8'h01, "halt wake time");
    chk({6'h0, mode_o}, {6'h0, MODE_NORMAL}, "halt wake normal");
    wr(ADDR_CTRL, 8'hc4);
    pulse(2);
    wait_run();
    chk({6'h0, mode_o}, {6'h0, MODE_SLOW}, "halt wake slow");
    complete_run();
  end
endmodule : testbench

// ---- verilog/mode_and_reset_sequencer.sv ----
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Contract
// - Gate oscillators, execution, timers, peripherals per mode.
// - Standby and halt wake on listed sources.
// - Four reset events enter reset state.
// - Reset loads defined values, unknowns kept.
// - Pin reset: flags kept, or set in halt.
// - Watchdog reset: flags 0/1, halt 0/0.
// - Power/low-voltage 1/1, sleep 1/0, clear 1/1.
// - Selectable power-up delay after reset release.
// - Then 16 start-up cycles before execution.
// - Halt by sleep or mode 01b.
// - Standby by mode 10b, high oscillator kept unless the stop bit is set.
// - Wake resumes normal or slow by select.
// - Halt wake waits 16 cycles, standby none.
module mode_and_reset_sequencer
  import mode_reset_pkg::*;
#(
  parameter int DLY0_CYCLES = PWRUP0_US * 1000 / CLK_PERIOD_NS,
  parameter int DLY1_CYCLES = PWRUP1_US * 1000 / CLK_PERIOD_NS,
  parameter int DLY2_CYCLES = PWRUP2_US * 1000 / CLK_PERIOD_NS,
  parameter int DLY3_CYCLES = PWRUP3_US * 1000 / CLK_PERIOD_NS,
  parameter int DLY4_CYCLES = PWRUP4_US * 1000 / CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Reset events
  input wire logic power_on_reset_i,
  input wire logic low_voltage_reset_i,
  input wire logic external_reset_pin_n_i,
  input wire logic watchdog_timeout_i,
  // Wake-up sources
  input wire logic timer0_overflow_i,
  input wire logic timer1_underflow_i,
  input wire logic portb_change_i,
  input wire logic ext_int_i,
  input wire logic low_voltage_detect_i,
  // Core instruction pulses
  input wire logic sleep_instruction_i,
  input wire logic watchdog_clear_instruction_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Resource gating
  output logic high_frequency_clock_en_o,
  output logic low_frequency_clock_en_o,
  output logic exec_en_o,
  output logic timer0_run_o,
  output logic timer1_run_o,
  output logic watchdog_run_o,
  output logic periph_en_o,
  output logic watchdog_clear_o,
  output logic sys_reset_o,
  output logic [1:0] mode_o,
  output logic irq_o
);

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] delay_load(input logic [2:0] sel);
    int n;
    unique case (sel)
      3'h0: n = DLY0_CYCLES;
      3'h1: n = DLY1_CYCLES;
      3'h2: n = DLY2_CYCLES;
      3'h3: n = DLY3_CYCLES;
      default: n = DLY4_CYCLES;
    endcase
    if (n < 1) begin
      n = 1;
    end
    return CNT_W'(n - 1);
  endfunction : delay_load

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : is_addr

  // ==========================================================
  // State
  seq_state_t state;
  seq_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [7:0] ctrl;
  logic [2:0] config_sel;
  logic timeout_flag_n;
  logic powerdown_flag_n;
  logic [3:0] int_status;
  logic [3:0] int_mask;
  logic reset_any_q;
  logic wdt_clear_q;

  // ==========================================================
  // Decode
  wire logic reset_any = power_on_reset_i | low_voltage_reset_i
                       | ~external_reset_pin_n_i | watchdog_timeout_i;
  wire logic reset_rise = reset_any & ~reset_any_q;
  wire logic in_halt = (state == ST_HALT) || (state == ST_WAKE);
  wire logic running = (state == ST_RUN);
  wire logic high_osc_select_bit = ctrl[CTRL_HOSC_SEL];
  wire logic high_osc_stop_bit = ctrl[CTRL_HOSC_STOP];
  wire logic wr_ctrl = wr_i & running & is_addr(addr_i, ADDR_CTRL);
  wire logic wr_config = wr_i & is_addr(addr_i, ADDR_CONFIG);
  wire logic wr_int_status = wr_i & is_addr(addr_i, ADDR_INT_STATUS);
  wire logic wr_int_mask = wr_i & is_addr(addr_i, ADDR_INT_MASK);
  wire logic [1:0] wr_mode_field = wdata_i[CTRL_MODE_LO +: 2];
  wire logic enter_halt = running
                        & (sleep_instruction_i
                           | (wr_ctrl & (wr_mode_field == MODE_FIELD_HALT)));
  wire logic enter_standby = running & wr_ctrl
                           & (wr_mode_field == MODE_FIELD_STANDBY) & ~enter_halt;
  wire logic wake_standby = timer0_overflow_i | timer1_underflow_i
                          | watchdog_timeout_i | portb_change_i
                          | ext_int_i | low_voltage_detect_i;
  wire logic wake_halt = watchdog_timeout_i | portb_change_i | ext_int_i;
  wire logic cnt_done = (cnt == '0);

  // ==========================================================
  // Sequencer
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    if (reset_any) begin
      next_state = ST_RESET;
    end else begin
      unique case (state)
        ST_RESET: begin
          next_state = ST_PWRUP;
          next_cnt = delay_load(config_sel);
        end
        ST_PWRUP: begin
          next_cnt = cnt - 1'b1;
          if (cnt_done) begin
            next_state = ST_STARTUP;
            next_cnt = STARTUP_CYCLES - 1'b1;
          end
        end
        ST_STARTUP, ST_WAKE: begin
          next_cnt = cnt - 1'b1;
          if (cnt_done) begin
            next_state = ST_RUN;
          end
        end
        ST_RUN: begin
          if (enter_halt) begin
            next_state = ST_HALT;
          end else if (enter_standby) begin
            next_state = ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (wake_standby) begin
            next_state = ST_RUN;
          end
        end
        ST_HALT: begin
          if (wake_halt) begin
            next_state = ST_WAKE;
            next_cnt = STARTUP_CYCLES - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RESET;
      cnt <= '0;
      reset_any_q <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      reset_any_q <= reset_any;
    end
  end

  // ==========================================================
  // Control and config registers
  // Config has no defined value on reset events, so only rst_i clears it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= CTRL_INIT;
      config_sel <= CONFIG_INIT;
    end else begin
      if (reset_any) begin
        ctrl <= CTRL_INIT;
      end else if ((state == ST_STANDBY && wake_standby)
                   || (state == ST_WAKE && cnt_done)) begin
        ctrl[CTRL_MODE_LO +: 2] <= MODE_FIELD_RUN;
      end else if (wr_ctrl) begin
        ctrl <= wdata_i;
      end else if (enter_halt) begin
        ctrl[CTRL_MODE_LO +: 2] <= MODE_FIELD_HALT;
      end
      if (wr_config && !reset_any) begin
        config_sel <= wdata_i[2:0];
      end
    end
  end

  // ==========================================================
  // Timeout and power-down flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else if (reset_rise) begin
      if (power_on_reset_i || low_voltage_reset_i) begin
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end else if (!external_reset_pin_n_i) begin
        if (in_halt) begin
          timeout_flag_n <= 1'b1;
          powerdown_flag_n <= 1'b1;
        end
      end else begin
        timeout_flag_n <= 1'b0;
        powerdown_flag_n <= ~in_halt;
      end
    end else if (enter_halt) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b0;
    end else if (watchdog_clear_instruction_i && running) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  logic [3:0] irq_events;
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_RESET_DONE] = (state == ST_STARTUP) & cnt_done & ~reset_any;
    irq_events[IRQ_WAKE_STBY] = (state == ST_STANDBY) & wake_standby & ~reset_any;
    irq_events[IRQ_WAKE_HALT] = (state == ST_WAKE) & cnt_done & ~reset_any;
    irq_events[IRQ_WDT_RESET] = reset_rise & watchdog_timeout_i;
  end

  // A new event in the clearing cycle survives the write-one-to-clear.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_status <= IRQ_INIT;
      int_mask <= IRQ_INIT;
    end else begin
      int_status <= (int_status & ~(wr_int_status ? wdata_i[3:0] : 4'h0))
                  | irq_events;
      if (wr_int_mask) begin
        int_mask <= wdata_i[3:0];
      end
    end
  end

  assign irq_o = |(int_status & int_mask);

  // ==========================================================
  // Read port, data one cycle after the strobe
  logic [7:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[STAT_TIMEOUT] = timeout_flag_n;
    status_word[STAT_POWERDOWN] = powerdown_flag_n;
    status_word[STAT_MODE_LO +: 2] = mode_o;
    status_word[STAT_RESET] = sys_reset_o;
  end

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL: next_rdata = ctrl;
        ADDR_CONFIG: next_rdata = {5'h00, config_sel};
        ADDR_STATUS: next_rdata = status_word;
        ADDR_INT_STATUS: next_rdata = {4'h0, int_status};
        ADDR_INT_MASK: next_rdata = {4'h0, int_mask};
        default: next_rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
      wdt_clear_q <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      wdt_clear_q <= enter_halt;
    end
  end
  assign watchdog_clear_o = wdt_clear_q;

  // Halt kills both oscillators; the high one stays up through reset,
  // start-up and the halt wake count so each count has a clock to run on.
  always_comb begin
    unique case (state)
      ST_RUN: mode_o = high_osc_select_bit ? MODE_NORMAL : MODE_SLOW;
      ST_STANDBY: mode_o = MODE_STANDBY;
      ST_HALT, ST_WAKE: mode_o = MODE_HALT;
      default: mode_o = MODE_NORMAL;
    endcase
  end

  wire logic slow_like = (mode_o == MODE_SLOW) | (mode_o == MODE_STANDBY);
  assign high_frequency_clock_en_o = (state != ST_HALT)
                                   & ~(slow_like & high_osc_stop_bit);
  assign low_frequency_clock_en_o = (state != ST_HALT);
  assign exec_en_o = running;
  assign timer0_run_o = ~in_halt & (running | (state == ST_STANDBY))
                      & ctrl[CTRL_TIMER0_EN];
  assign timer1_run_o = ~in_halt & (running | (state == ST_STANDBY))
                      & ctrl[CTRL_TIMER1_EN];
  assign watchdog_run_o = ctrl[CTRL_WATCHDOG_EN];
  assign periph_en_o = ~in_halt & (running | (state == ST_STANDBY))
                     & ctrl[CTRL_PERIPH];
  assign sys_reset_o = ~running & ~(state == ST_STANDBY) & ~in_halt;

endmodule : mode_and_reset_sequencer

// ---- verilog/mode_reset_pkg.sv ----
package mode_reset_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_INT_MASK = 8'h10;

  // ==========================================================
  // Control register fields
  localparam int CTRL_HOSC_SEL = 0;
  localparam int CTRL_HOSC_STOP = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_TIMER0_EN = 4;
  localparam int CTRL_TIMER1_EN = 5;
  localparam int CTRL_WATCHDOG_EN = 6;
  localparam int CTRL_PERIPH = 7;
  localparam logic [7:0] CTRL_INIT = 8'hc1;
  localparam logic [1:0] MODE_FIELD_RUN = 2'h0;
  localparam logic [1:0] MODE_FIELD_HALT = 2'h1;
  localparam logic [1:0] MODE_FIELD_STANDBY = 2'h2;

  // ==========================================================
  // Status, interrupt and config fields
  localparam int STAT_TIMEOUT = 0;
  localparam int STAT_POWERDOWN = 1;
  localparam int STAT_MODE_LO = 2;
  localparam int STAT_RESET = 4;
  localparam int IRQ_RESET_DONE = 0;
  localparam int IRQ_WAKE_STBY = 1;
  localparam int IRQ_WAKE_HALT = 2;
  localparam int IRQ_WDT_RESET = 3;
  localparam logic [3:0] IRQ_INIT = 4'h0;
  localparam logic [2:0] CONFIG_INIT = 3'h0;

  // Reported operating mode
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLOW = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int PWRUP0_US = 140;
  localparam int PWRUP1_US = 4500;
  localparam int PWRUP2_US = 18000;
  localparam int PWRUP3_US = 72000;
  localparam int PWRUP4_US = 288000;
  localparam int CNT_W = 27;
  localparam logic [CNT_W-1:0] STARTUP_CYCLES = 27'h10;

  typedef enum logic [2:0] {
    ST_RESET, ST_PWRUP, ST_STARTUP, ST_RUN, ST_STANDBY, ST_HALT, ST_WAKE
  } seq_state_t;

endpackage : mode_reset_pkg
